/* File: include/tbr_params.svh */
`ifndef TBR_PARAMS_SVH
`define TBR_PARAMS_SVH
// clock and timebase
`define TBR_CLK_MHZ       125
`define TBR_TICK_NS       1000
// durations in timebase ticks (microseconds)
`define TBR_TIMEOUT_US    30000
`define TBR_GAP_US        40
`define TBR_IDLE_US       100
// recovery clock rate and pulse budget
`define TBR_REC_HZ        8500
`define TBR_REC_PULSES    5'h10
// cycles a released pair waits before watching again
`define TBR_SETTLE_CYC    3'h4
// register map
`define TBR_CTRL_OFF      8'h00
`define TBR_STAT_OFF      8'h04
`define TBR_CTRL_EN_BIT   0
`define TBR_CTRL_RST      32'h0000_0001
`define TBR_RESP_OKAY     2'h0
`define TBR_RESP_DECERR   2'h3
`endif

/* File: include/tbr_pkg.sv */
package tbr_pkg;
    // connection controller states, one-hot
    typedef enum logic [6:0] {
        ST_LOCK  = 7'h01,
        ST_WAIT  = 7'h02,
        ST_CONN  = 7'h04,
        ST_GAP   = 7'h08,
        ST_PULSE = 7'h10,
        ST_STOP  = 7'h20,
        ST_REARM = 7'h40
    } tbr_state_t;
    // which side of a pair is pulling low
    typedef enum logic [1:0] {
        OWN_NONE = 2'h0,
        OWN_ISO  = 2'h1,
        OWN_REC  = 2'h2
    } tbr_owner_t;
endpackage : tbr_pkg

/* File: rtl/tbr_buffer.sv */
`timescale 1ns/1ns
`include "tbr_params.svh"
// Function
// - during supply lockout ignore both buses and keep precharge on
// - after lockout watch both segments for stop or idle
// - join only if both idle, or one stops while other idle
// - precharge off at connect, back on only in lockout
// - connected: a low on either side of a pair drives the other low
// - a connected pair goes high only when every device released it
// - start stuck timer while recovery data or clock is low
// - a line's stuck timer restarts when that line goes high, in lockout, during recovery or on a forced connection
// - line low for full timeout breaks data and clock connections
// - wait minimum gap, then up to sixteen recovery clock pulses
// - after the pulses issue a stop on recovery clock and data
// - stuck line high arms reconnection after stop or idle
// - stuck at power-up: no join until high, recover after timeout
// - ready low if disabled, starting or stuck; high when connected
// - enable low keeps segments apart and ready low
// - enable rising after stuck event forces the connection
// - forced connection restarts the stuck timer and keeps it running
// - accelerators on once connected
// - accelerators off until start-up done and during recovery
module tbr_buffer #(
    parameter int unsigned TIMEOUT_TK = `TBR_TIMEOUT_US, // stuck timeout, ticks
    parameter int unsigned GAP_TK     = `TBR_GAP_US,     // gap before pulses
    parameter int unsigned IDLE_TK    = `TBR_IDLE_US,    // high time for idle
    parameter int unsigned HALF_TK    = 1000000 / (2 * `TBR_REC_HZ) // half pulse
) (
    input  wire logic        aclk,          // system clock
    input  wire logic        aresetn,       // sync reset, low
    input  wire logic        supply_lockout,// supply below lockout level
    input  wire logic        enable,        // connection enable pin
    input  wire logic        iso_sda_i,     // isolated_side_data level
    output logic             iso_sda_o,     // always low
    output logic             iso_sda_oe,    // pull isolated data low
    input  wire logic        iso_scl_i,     // isolated_side_clock level
    output logic             iso_scl_o,     // always low
    output logic             iso_scl_oe,    // pull isolated clock low
    input  wire logic        rec_sda_i,     // recovery_side_data level
    output logic             rec_sda_o,     // always low
    output logic             rec_sda_oe,    // pull recovery data low
    input  wire logic        rec_scl_i,     // recovery_side_clock level
    output logic             rec_scl_o,     // always low
    output logic             rec_scl_oe,    // pull recovery clock low
    output logic             ready_o,       // always low
    output logic             ready_oe,      // pull ready low
    output logic             precharge_on,  // precharge active
    output logic             accel_on,      // accelerators enabled
    input  wire logic [7:0]  s_axi_awaddr,  // write address
    input  wire logic        s_axi_awvalid, // write address valid
    output logic             s_axi_awready, // write address ready
    input  wire logic [31:0] s_axi_wdata,   // write data
    input  wire logic [3:0]  s_axi_wstrb,   // write strobes
    input  wire logic        s_axi_wvalid,  // write data valid
    output logic             s_axi_wready,  // write data ready
    output logic [1:0]       s_axi_bresp,   // write response
    output logic             s_axi_bvalid,  // write response valid
    input  wire logic        s_axi_bready,  // write response ready
    input  wire logic [7:0]  s_axi_araddr,  // read address
    input  wire logic        s_axi_arvalid, // read address valid
    output logic             s_axi_arready, // read address ready
    output logic [31:0]      s_axi_rdata,   // read data
    output logic [1:0]       s_axi_rresp,   // read response
    output logic             s_axi_rvalid,  // read data valid
    input  wire logic        s_axi_rready   // read data ready
);
    localparam int unsigned TICK_CYC = `TBR_TICK_NS * `TBR_CLK_MHZ / 1000;

    tbr_pkg::tbr_state_t st_q;
    tbr_pkg::tbr_owner_t own_q [2];
    logic [5:0]  s1_q, s2_q;
    logic [6:0]  tick_cnt_q;
    logic        tick;
    logic [1:0]  iso_l, rec_l, drv_iso, drv_rec;
    logic [2:0]  settle_q [2];
    logic [1:0]  sda_prev_q, scl_prev_q, stop_seen, idle;
    logic [15:0] idle_cnt_q [2];
    logic [15:0] stk_cnt_q [2];
    logic        stuck_hit, stuck_q, en_prev_q, en_eff, en_rise, joinable;
    logic [15:0] tmr_q;
    logic [4:0]  pcnt_q;
    logic [1:0]  ph_q;
    logic        rec_sda_drv, rec_scl_drv, prech_q, ctrl_en_q;
    logic        lock_s, en_s, rec_scl, rec_sda, iso_scl, iso_sda;

    // timer expiry compare, used by the idle, stuck and recovery tick counters
    function automatic logic tk_done(input logic [15:0] cnt, input int unsigned lim);
        tk_done = (cnt >= 16'(lim));
    endfunction : tk_done

    // two-flop synchronisers on every pin input
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s1_q <= 6'h3F;
            s2_q <= 6'h3F;
        end
        else
        begin
            s1_q <= {supply_lockout, enable, rec_scl_i, rec_sda_i, iso_scl_i, iso_sda_i};
            s2_q <= s1_q;
        end
    end

    assign {lock_s, en_s, rec_scl, rec_sda, iso_scl, iso_sda} = s2_q;
    assign iso_l    = {~iso_scl, ~iso_sda};
    assign rec_l    = {~rec_scl, ~rec_sda};
    assign en_eff   = en_s & ctrl_en_q;
    assign en_rise  = en_eff & ~en_prev_q;

    // one-microsecond timebase
    always_ff @(posedge aclk)
    begin
        if (!aresetn || tick)
            tick_cnt_q <= 7'h00;
        else
            tick_cnt_q <= tick_cnt_q + 7'h01;
    end
    assign tick = (tick_cnt_q == 7'(TICK_CYC - 1));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            en_prev_q <= 1'b0;
        else
            en_prev_q <= en_eff;
    end

    // stop and idle watch on both segments, index 0 isolated, 1 recovery
    assign stop_seen[0] = iso_scl & iso_sda & scl_prev_q[0] & ~sda_prev_q[0];
    assign stop_seen[1] = rec_scl & rec_sda & scl_prev_q[1] & ~sda_prev_q[1];
    assign idle[0]      = tk_done(idle_cnt_q[0], IDLE_TK);
    assign idle[1]      = tk_done(idle_cnt_q[1], IDLE_TK);
    assign joinable     = (idle[0] & idle[1]) | (stop_seen[0] & idle[1])
                        | (stop_seen[1] & idle[0]);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sda_prev_q <= 2'h3;
            scl_prev_q <= 2'h3;
        end
        else
        begin
            sda_prev_q <= {rec_sda, iso_sda};
            scl_prev_q <= {rec_scl, iso_scl};
        end
    end

    for (genvar j = 0; j < 2; j++)
    begin : g_side
        // idle counter: both lines of a side high for the idle time
        always_ff @(posedge aclk)
        begin
            if (!aresetn || lock_s || iso_l[j] && j == 0 || rec_l[j] && j == 1
                || (j == 0 ? (iso_l != 2'h0) : (rec_l != 2'h0)))
                idle_cnt_q[j] <= 16'h0000;
            else if (tick && !idle[j])
                idle_cnt_q[j] <= idle_cnt_q[j] + 16'h0001;
        end

        // stuck timer per recovery line, j 0 data, 1 clock
        always_ff @(posedge aclk)
        begin
            if (!aresetn || lock_s || !rec_l[j] || st_q == tbr_pkg::ST_GAP
                || st_q == tbr_pkg::ST_PULSE || st_q == tbr_pkg::ST_STOP)
                stk_cnt_q[j] <= 16'h0000;
            else if (en_rise && stuck_q)
                stk_cnt_q[j] <= 16'h0000;
            else if (tick && !tk_done(stk_cnt_q[j], TIMEOUT_TK))
                stk_cnt_q[j] <= stk_cnt_q[j] + 16'h0001;
        end

        // pair mirror: remember which side pulled first, drive the other
        always_ff @(posedge aclk)
        begin
            if (!aresetn || st_q != tbr_pkg::ST_CONN)
            begin
                own_q[j]    <= tbr_pkg::OWN_NONE;
                settle_q[j] <= 3'h0;
            end
            else
            begin
                case (own_q[j])
                    tbr_pkg::OWN_NONE:
                    begin
                        if (settle_q[j] != 3'h0)
                            settle_q[j] <= settle_q[j] - 3'h1;
                        else if (iso_l[j])
                            own_q[j] <= tbr_pkg::OWN_ISO;
                        else if (rec_l[j])
                            own_q[j] <= tbr_pkg::OWN_REC;
                    end
                    tbr_pkg::OWN_ISO:
                    begin
                        if (!iso_l[j])
                        begin
                            own_q[j]    <= tbr_pkg::OWN_NONE;
                            settle_q[j] <= `TBR_SETTLE_CYC;
                        end
                    end
                    tbr_pkg::OWN_REC:
                    begin
                        if (!rec_l[j])
                        begin
                            own_q[j]    <= tbr_pkg::OWN_NONE;
                            settle_q[j] <= `TBR_SETTLE_CYC;
                        end
                    end
                    default:
                        own_q[j] <= tbr_pkg::OWN_NONE;
                endcase
            end
        end
        assign drv_rec[j] = (own_q[j] == tbr_pkg::OWN_ISO);
        assign drv_iso[j] = (own_q[j] == tbr_pkg::OWN_REC);
    end

    assign stuck_hit = tk_done(stk_cnt_q[0], TIMEOUT_TK)
                     | tk_done(stk_cnt_q[1], TIMEOUT_TK);

    // connection controller
    always_ff @(posedge aclk)
    begin
        if (!aresetn || lock_s)
            st_q <= tbr_pkg::ST_LOCK;
        else
        begin
            case (st_q)
                tbr_pkg::ST_LOCK:
                    st_q <= tbr_pkg::ST_WAIT;
                tbr_pkg::ST_WAIT, tbr_pkg::ST_REARM:
                begin
                    if (en_rise && stuck_q)
                        st_q <= tbr_pkg::ST_CONN;
                    else if (stuck_hit)
                        st_q <= tbr_pkg::ST_GAP;
                    else if (st_q == tbr_pkg::ST_REARM && !rec_l[0] && !rec_l[1])
                        st_q <= tbr_pkg::ST_WAIT;
                    else if (st_q == tbr_pkg::ST_WAIT && en_eff && joinable)
                        st_q <= tbr_pkg::ST_CONN;
                end
                tbr_pkg::ST_CONN:
                begin
                    if (!en_eff)
                        st_q <= tbr_pkg::ST_WAIT;
                    else if (stuck_hit)
                        st_q <= tbr_pkg::ST_GAP;
                end
                tbr_pkg::ST_GAP:
                    if (tick && tk_done(tmr_q, GAP_TK - 1))
                        st_q <= tbr_pkg::ST_PULSE;
                tbr_pkg::ST_PULSE:
                    if (tick && tk_done(tmr_q, HALF_TK - 1) && ph_q[0]
                        && (pcnt_q == `TBR_REC_PULSES - 5'h01 || rec_sda))
                        st_q <= tbr_pkg::ST_STOP;
                tbr_pkg::ST_STOP:
                    if (tick && tk_done(tmr_q, HALF_TK - 1) && ph_q == 2'h2)
                        st_q <= tbr_pkg::ST_REARM;
                default:
                    st_q <= tbr_pkg::ST_LOCK;
            endcase
        end
    end

    // recovery timer, phase and pulse count
    always_ff @(posedge aclk)
    begin
        if (!aresetn || st_q == tbr_pkg::ST_CONN || st_q == tbr_pkg::ST_WAIT
            || st_q == tbr_pkg::ST_LOCK || st_q == tbr_pkg::ST_REARM)
        begin
            tmr_q  <= 16'h0000;
            ph_q   <= 2'h0;
            pcnt_q <= 5'h00;
        end
        else if (tick)
        begin
            if ((st_q == tbr_pkg::ST_GAP && tk_done(tmr_q, GAP_TK - 1))
                || (st_q != tbr_pkg::ST_GAP && tk_done(tmr_q, HALF_TK - 1)))
            begin
                tmr_q <= 16'h0000;
                if (st_q == tbr_pkg::ST_PULSE)
                begin
                    ph_q <= {1'b0, ~ph_q[0]};
                    if (ph_q[0])
                        pcnt_q <= pcnt_q + 5'h01;
                    if (ph_q[0] && st_q != tbr_pkg::ST_PULSE)
                        ph_q <= 2'h0;
                end
                else if (st_q == tbr_pkg::ST_STOP)
                    ph_q <= ph_q + 2'h1;
                else
                    ph_q <= 2'h0;
            end
            else
                tmr_q <= tmr_q + 16'h0001;
        end
    end

    // recovery clock low in first half of each pulse; stop sequence
    assign rec_scl_drv = (st_q == tbr_pkg::ST_PULSE && !ph_q[0])
                       | (st_q == tbr_pkg::ST_STOP && ph_q == 2'h0);
    assign rec_sda_drv = (st_q == tbr_pkg::ST_STOP && ph_q != 2'h2);

    // stuck flag, precharge and pin drivers
    always_ff @(posedge aclk)
    begin
        if (!aresetn || lock_s)
        begin
            stuck_q <= 1'b0;
            prech_q <= 1'b1;
        end
        else if (st_q == tbr_pkg::ST_CONN)
        begin
            stuck_q <= stuck_hit;
            prech_q <= 1'b0;
        end
        else if (stuck_hit)
            stuck_q <= 1'b1;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {iso_sda_oe, iso_scl_oe, rec_sda_oe, rec_scl_oe} <= 4'h0;
            ready_oe <= 1'b1;
            accel_on <= 1'b0;
        end
        else
        begin
            iso_sda_oe <= drv_iso[0];
            iso_scl_oe <= drv_iso[1];
            rec_sda_oe <= drv_rec[0] | rec_sda_drv;
            rec_scl_oe <= drv_rec[1] | rec_scl_drv;
            ready_oe   <= !(st_q == tbr_pkg::ST_CONN && en_eff);
            accel_on   <= (st_q == tbr_pkg::ST_CONN);
        end
    end
    assign {iso_sda_o, iso_scl_o, rec_sda_o, rec_scl_o, ready_o} = 5'h00;
    assign precharge_on = prech_q;

    // register slave: write takes address and data together
    assign s_axi_awready = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
    assign s_axi_wready  = s_axi_awready;
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_en_q    <= 1'(`TBR_CTRL_RST);
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `TBR_RESP_OKAY;
        end
        else if (s_axi_awready)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (s_axi_awaddr == `TBR_CTRL_OFF || s_axi_awaddr == `TBR_STAT_OFF)
                          ? `TBR_RESP_OKAY : `TBR_RESP_DECERR;
            if (s_axi_awaddr == `TBR_CTRL_OFF && s_axi_wstrb[0])
                ctrl_en_q <= s_axi_wdata[`TBR_CTRL_EN_BIT];
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `TBR_RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= `TBR_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == `TBR_CTRL_OFF)
                s_axi_rdata <= {31'h0, ctrl_en_q};
            else if (s_axi_araddr == `TBR_STAT_OFF)
                s_axi_rdata <= {16'h0, 1'b0, st_q, accel_on, prech_q,
                                stuck_q, ~ready_oe, en_s, lock_s, 2'h0};
            else
                s_axi_rresp <= `TBR_RESP_DECERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    // checks
    sequence s_pulse_to_stop;
        st_q == tbr_pkg::ST_PULSE ##1 st_q == tbr_pkg::ST_STOP;
    endsequence
    sequence s_conn_trip;
        st_q == tbr_pkg::ST_CONN && stuck_hit && en_eff && !lock_s;
    endsequence

    // owner and pin flops drain one cycle apiece after the state drops to lockout
    lock_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
        lock_s ##1 lock_s ##1 lock_s |=> !(iso_sda_oe | iso_scl_oe | rec_sda_oe | rec_scl_oe))
        else $error("lines driven in lockout");
    prech_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(prech_q) |-> $past(st_q) == tbr_pkg::ST_CONN)
        else $error("precharge dropped without connect");
    prech_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(prech_q) |-> $past(lock_s))
        else $error("precharge back on outside lockout");
    mirror_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == tbr_pkg::ST_CONN && own_q[0] == tbr_pkg::OWN_ISO |=> rec_sda_oe)
        else $error("data low not mirrored");
    release_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == tbr_pkg::ST_CONN && own_q[1] == tbr_pkg::OWN_REC && rec_l[1]
        && en_eff && !stuck_hit && !lock_s |=> own_q[1] == tbr_pkg::OWN_REC)
        else $error("clock released while held");
    trip_break_a: assert property (@(posedge aclk) disable iff (!aresetn)
        s_conn_trip |=> st_q == tbr_pkg::ST_GAP ##2 !accel_on)
        else $error("stuck bus not broken");
    gap_len_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(st_q) == tbr_pkg::ST_GAP && st_q == tbr_pkg::ST_PULSE
        |-> $past(tmr_q) == 16'(GAP_TK - 1))
        else $error("gap too short");
    pulse_max_a: assert property (@(posedge aclk) disable iff (!aresetn)
        st_q == tbr_pkg::ST_PULSE |-> pcnt_q < `TBR_REC_PULSES)
        else $error("too many pulses");
    stop_gen_a: assert property (@(posedge aclk) disable iff (!aresetn || lock_s)
        s_pulse_to_stop |=> rec_sda_oe && rec_scl_oe)
        else $error("stop not started");
    ready_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !ready_oe |-> $past(st_q) == tbr_pkg::ST_CONN && $past(en_eff))
        else $error("ready high while not connected");
    force_a: assert property (@(posedge aclk) disable iff (!aresetn)
        en_rise && stuck_q && !lock_s
        && (st_q == tbr_pkg::ST_WAIT || st_q == tbr_pkg::ST_REARM)
        |=> st_q == tbr_pkg::ST_CONN)
        else $error("forced connect missed");
    accel_a: assert property (@(posedge aclk) disable iff (!aresetn)
        accel_on |-> $past(st_q) == tbr_pkg::ST_CONN)
        else $error("accelerators on outside connection");
endmodule : tbr_buffer

/* File: testbench/tbr_bus_model.sv */
`timescale 1ns/1ns
// devices on both segments; order iso_sda, iso_scl, rec_sda, rec_scl
module tbr_bus_model (
    input  wire logic [3:0] dev_oe,   // buffer pulling low
    input  wire logic [3:0] ext_pull, // bus devices pulling low
    output logic      [3:0] wire_lvl  // resolved line levels
);
    // open drain with pull-ups, devices pull to a full low
    assign wire_lvl = ~(dev_oe | ext_pull);
endmodule : tbr_bus_model

/* File: testbench/tbr_buffer_tb_top.sv */
`timescale 1ns/1ns
`include "tbr_params.svh"
module tbr_buffer_tb_top;
    localparam int TK = 125; // clocks per tick
    logic        aclk = 0, aresetn = 0, lock = 1;
    logic        en   = 0; // low through insertion
    logic [3:0]  pull = 4'h3, oe, oe_q = 4'h0, lvl;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic        awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic        awr, wr, bv, arr, rv, rdy_oe, pre, acc;
    logic [1:0]  bresp, rresp, rs;
    int          err_total = 0, compares = 0, cyc = 0, scl_r = 0, sda_r = 0;

    always #4 aclk = ~aclk;

    tbr_buffer #(.TIMEOUT_TK(50), .GAP_TK(3), .IDLE_TK(5), .HALF_TK(4)) u_tbr_buffer (
        .aclk(aclk), .aresetn(aresetn), .supply_lockout(lock), .enable(en),
        .iso_sda_i(lvl[0]), .iso_sda_o(), .iso_sda_oe(oe[0]),
        .iso_scl_i(lvl[1]), .iso_scl_o(), .iso_scl_oe(oe[1]),
        .rec_sda_i(lvl[2]), .rec_sda_o(), .rec_sda_oe(oe[2]),
        .rec_scl_i(lvl[3]), .rec_scl_o(), .rec_scl_oe(oe[3]),
        .ready_o(), .ready_oe(rdy_oe), .precharge_on(pre), .accel_on(acc),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rready));
    tbr_bus_model u_tbr_bus_model (.dev_oe(oe), .ext_pull(pull), .wire_lvl(lvl));

    // count recovery drive edges, cut a hang short
    always @(posedge aclk)
    begin
        oe_q <= oe;
        scl_r <= scl_r + int'(oe[3] & ~oe_q[3]);
        sda_r <= sda_r + int'(oe[2] & ~oe_q[2]);
        cyc <= cyc + 1;
        if (cyc == 90000)
        begin
            err_total = err_total + 1;
            print_verdict();
        end
    end

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task cy(input int n);
        repeat (n) @(posedge aclk);
    endtask : cy

    // wait up to n clocks for a ready level
    task wrdy(input logic v, input int n);
        for (int i = 0; i < n && rdy_oe !== v; i++) @(posedge aclk);
    endtask : wrdy

    task axi_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        @(posedge aclk);
        while (!(awr && wr)) @(posedge aclk);
        awv <= 1'b0;
        wv <= 1'b0;
        while (!bv) @(posedge aclk);
        bready <= 1'b0;
        chk(bresp, `TBR_RESP_OKAY);
    endtask : axi_wr

    task axi_rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        @(posedge aclk);
        while (!arr) @(posedge aclk);
        arv <= 1'b0;
        while (!rv) @(posedge aclk);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // isolated side held busy in lockout, then a frame ending in a stop
    task t_start;
        cy(2 * TK);
        chk(oe, 4'h0);
        chk(pre, 1'b1);
        chk(rdy_oe, 1'b1);
        en <= 1'b1;
        lock <= 1'b0;
        cy(6 * TK);
        pull <= 4'h1;
        cy(5);
        repeat (16)
        begin
            pull[1] <= ~pull[1];
            cy(5);
        end
        chk(rdy_oe, 1'b1);
        pull <= 4'h0;
        wrdy(1'b0, 100);
        chk(rdy_oe, 1'b0);
        chk(pre, 1'b0);
        chk(acc, 1'b1);
    endtask : t_start

    task t_mirror;
        pull <= 4'h1;
        cy(10);
        chk(lvl[2], 1'b0);
        pull <= 4'h5;
        cy(10);
        pull <= 4'h4;
        cy(20);
        chk(lvl[0], 1'b0);
        pull <= 4'h8;
        cy(20);
        chk(lvl, 4'h5);
        pull <= 4'h0;
        cy(20);
        chk(lvl, 4'hF);
    endtask : t_mirror

    task t_regs;
        axi_rd(`TBR_STAT_OFF);
        chk(rd[3], 1'b1);
        axi_rd(8'h08);
        chk(rs, `TBR_RESP_DECERR);
        chk(rd, 32'h0);
        axi_wr(`TBR_CTRL_OFF, 32'h0);
        cy(10);
        chk(rdy_oe, 1'b1);
        pull <= 4'h1;
        cy(10);
        chk(lvl[2], 1'b1);
        pull <= 4'h0;
        axi_rd(`TBR_CTRL_OFF);
        chk(rd, 32'h0);
        axi_wr(`TBR_CTRL_OFF, `TBR_CTRL_RST);
        wrdy(1'b0, 7 * TK);
        chk(rdy_oe, 1'b0);
        pull <= 4'h4;
        cy(40 * TK);
        pull <= 4'h0;
        cy(20);
        pull <= 4'h4;
        cy(40 * TK);
        chk(rdy_oe, 1'b0);
    endtask : t_regs

    task t_stuck;
        int s0, d0;
        cy(5 * TK);
        chk(rdy_oe, 1'b0);
        wrdy(1'b1, 10 * TK);
        chk(rdy_oe, 1'b1);
        // pin drive lags the ready flag by the owner flop
        cy(2);
        chk(oe[0], 1'b0);
        s0 = scl_r;
        d0 = sda_r;
        cy(20 * TK);
        chk(acc, 1'b0);
        cy(140 * TK);
        chk(scl_r - s0, `TBR_REC_PULSES + 1);
        chk(sda_r - d0, 1);
        chk(rdy_oe, 1'b1);
        en <= 1'b0;
        cy(10);
        en <= 1'b1;
        wrdy(1'b0, 20);
        chk(rdy_oe, 1'b0);
        cy(40 * TK);
        chk(rdy_oe, 1'b0);
        cy(20 * TK);
        chk(rdy_oe, 1'b1);
        pull <= 4'h0;
        wrdy(1'b0, 200 * TK);
        chk(rdy_oe, 1'b0);
    endtask : t_stuck

    task print_verdict;
        $display("err_total=%0d compares=%0d", err_total, compares);
        if (err_total == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        cy(5);
        aresetn <= 1'b1;
        t_start();
        t_mirror();
        t_regs();
        t_stuck();
        print_verdict();
    end
endmodule : tbr_buffer_tb_top
